// ==== logic/pfs_pin_mux.sv ====
/*
 * Pin function select multiplexer for ports A, B, C, E and J: per-pin
 * control registers, pad output routing, pad input fan-out to peripherals,
 * external interrupt line routing and analog/reference selection.
 * Assumes pads deliver asynchronous levels and peripherals share core_clk_in.
 */
`timescale 1ns/1ps
`include "pfs_map.svh"

// Overview of operation
// R01: five-bit select field per pin; code zero leaves the pin floating.
// R02: interrupt select clear keeps pin off its interrupt line; set routes it.
// R03: A3->6, A4->5, B1->4, E2->7, E5->5; A6 has no interrupt input.
// R04: analog bit set connects analog function; J6/J7 become converter references.
// R05: E0..E5 analog give channels 16..21; E1, E2, E4 also feed comparators.
// R06: legacy mode, J6 analog bit picks supply (clear) or high reference pin (set).
// R07: legacy mode, J7 analog bit picks ground (clear) or low reference pin (set).
// R08: A0 codes: timer 4A, clock reference in, SPI select 1, touch 32.
// R09: A1 codes: timer 0B, ext clock C, timer 3B, serial5 clock, SPI select 2, touch 31.
// R10: A3 codes: timer 0D, ext clock D, timer 4D, timer5 V, serial5 receive, touch 29.
// R11: A4 timer 4C, byte timer reset 0, touch 28; A6 timer 3D, count 3, enable 2, touch 26.
// R12: B0 timer 3D, serial6 rx, touch 25; B1 4C, count 0, serial6 tx, comparator, touch 24.
// R13: B3 codes: timer 0A, 4A, byte timer out 0, enable 3, serial6 clock, touch 22, lptimer.
// R14: B5, B6, B7 decode their timer, serial9 and touch codes; only B5 also has an enable code.
// R15: C4 codes: timer 3D, 0A, count 1, enable 0, serial5 clock, serial8 flow, touch cap.
// R16: C5..C7 serial8 clock/rx/tx, byte timer reset/count/out 2, touch 15..13, C7 lptimer.
// R17: C2, C3 timer 4B/4D, serial5 rx/tx, touch 17/16.
// R18: E3 timer 4B, 1B, enable 8, clock out, serial12 flow, touch 34; E1/E2 timer codes.
// R19: E4 timer 4D, 1A, 4A, clock out, touch 33; E5 timer 4C, 2B, comparator out 0.
// R20: port C pins have no interrupt select bit and no interrupt routing.
// R21: any unassigned select code leaves the pin floating like code zero.
// R22: written code routes from next cycle; analog bit blocks digital input paths.
module pfs_pin_mux #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [`PFS_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [`PFS_DATA_W-1:0] reg_rdata_out,
	input wire logic [`PFS_NUM_PINS-1:0] pad_in,
	output logic [`PFS_NUM_PINS-1:0] pad_out,
	output logic [`PFS_NUM_PINS-1:0] pad_oe_out,
	input pfs_pkg::pfs_drive_t periph_drive_in [`PFS_NUM_PINS],
	output logic [`PFS_NUM_CODES-1:0] periph_rx_out [`PFS_NUM_PINS],
	output logic [`PFS_NUM_IRQ-1:0] external_interrupt_line_out,
	output logic [`PFS_NUM_PINS-1:0] analog_connect_out,
	output logic [5:0] converter_channel_out,
	output logic [2:0] comparator_connect_out,
	output logic converter_high_reference_out,
	output logic converter_low_reference_out
);

	localparam int NP = `PFS_NUM_PINS;
	localparam int NC = `PFS_NUM_CODES;
	localparam int PIN_E0 = 17;
	localparam int PIN_E1 = 18;
	localparam int PIN_E2 = 19;
	localparam int PIN_E4 = 21;
	localparam int PIN_J6 = 23;
	localparam int PIN_J7 = 24;

	// pin order: A0 A1 A3 A4 A6 B0 B1 B3 B5 B6 B7 C2..C7 E0..E5 J6 J7
	localparam logic [7:0] OFFS [NP] = '{
		`PFS_OFF_PA0, `PFS_OFF_PA1, `PFS_OFF_PA3, `PFS_OFF_PA4, `PFS_OFF_PA6,
		`PFS_OFF_PB0, `PFS_OFF_PB1, `PFS_OFF_PB3, `PFS_OFF_PB5, `PFS_OFF_PB6,
		`PFS_OFF_PB7, `PFS_OFF_PC2, `PFS_OFF_PC3, `PFS_OFF_PC4, `PFS_OFF_PC5,
		`PFS_OFF_PC6, `PFS_OFF_PC7, `PFS_OFF_PE0, `PFS_OFF_PE1, `PFS_OFF_PE2,
		`PFS_OFF_PE3, `PFS_OFF_PE4, `PFS_OFF_PE5, `PFS_OFF_PJ6, `PFS_OFF_PJ7
	};

	// assigned select codes per pin, bit n = code n; zero bit never set
	localparam logic [NC-1:0] VALID [NP] = '{
		32'h02002082, // A0  see R08
		32'h0200240e, // A1  see R09
		32'h0200041e, // A3  see R10
		32'h0200242e, // A4  see R11
		32'h020028ae, // A6  see R11
		32'h02002806, // B0  see R12
		32'h02010826, // B1  see R12
		32'h0a0008a6, // B3  see R13
		32'h020004a6, // B5  see R14
		32'h02000402, // B6  see R14
		32'h02000402, // B7  see R14
		32'h02002402, // C2  see R17
		32'h02000402, // C3  see R17
		32'h02002cae, // C4  see R15
		32'h0200242e, // C5  see R16
		32'h02002426, // C6  see R16
		32'h0a0024a6, // C7  see R16
		32'h00001000, // E0
		32'h00001002, // E1  see R18
		32'h02001002, // E2  see R18
		32'h02001286, // E3  see R18
		32'h0200020e, // E4  see R19
		32'h00010006, // E5  see R19
		32'h00000000, // J6
		32'h00000000  // J7
	};

	// implemented bits per register; interrupt bit only where a line exists
	localparam logic [7:0] WMASK [NP] = '{
		8'h9f, 8'h9f, 8'hdf, 8'hdf, 8'h9f,
		8'h1f, 8'h5f, 8'h1f, 8'h1f, 8'h1f, 8'h1f,
		8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, // port C: no interrupt bit, see R20
		8'h9f, 8'h9f, 8'hdf, 8'h9f, 8'h9f, 8'hdf,
		8'h80, 8'h80
	};

	// interrupt routing: {present, line}
	localparam logic [3:0] IRQ_MAP [NP] = '{
		4'h0, 4'h0, 4'he, 4'hd, 4'h0, // A3->6, A4->5, A6 none  see R03
		4'h0, 4'hc, 4'h0, 4'h0, 4'h0, 4'h0, // B1->4  see R03
		4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0,
		4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'hd, // E2->7, E5->5  see R03
		4'h0, 4'h0
	};

	if (ADDR_W < 5 || ADDR_W > 16) begin : g_bad_addr
		$error("pfs_pin_mux: ADDR_W must lie between 5 and 16");
	end

	pfs_pkg::pfs_cfg_t cfg_reg [NP];
	pfs_pkg::pfs_cfg_t cfg_next [NP];
	logic legacy_mode_reg;
	logic legacy_mode_next;
	logic [NP-1:0] pad_meta_reg;
	logic [NP-1:0] pad_sync_reg;
	logic [NP-1:0] pad_out_next;
	logic [NP-1:0] pad_oe_next;
	logic [NC-1:0] rx_next [NP];
	logic [NP-1:0] dig_block;
	logic [NP-1:0] irq_active;
	logic [`PFS_NUM_IRQ-1:0] irq_next;
	logic [`PFS_DATA_W-1:0] rdata_next;
	logic [NP-1:0] ana_next;
	logic [7:0] addr8;

	assign addr8 = 8'(reg_addr_in);

	// pad synchroniser; first stage is read by the second only
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			pad_meta_reg <= '0;
			pad_sync_reg <= '0;
		end else begin
			pad_meta_reg <= pad_in;
			pad_sync_reg <= pad_meta_reg;
		end
	end

	// legacy reference mode register
	always_comb begin
		legacy_mode_next = legacy_mode_reg;
		if (reg_wr_in && addr8 == `PFS_OFF_MODE) begin
			legacy_mode_next = reg_wdata_in[`PFS_FLD_LEGACY_BIT];
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			legacy_mode_reg <= `PFS_RST_MODE;
		end else begin
			legacy_mode_reg <= legacy_mode_next;
		end
	end

	for (genvar p = 0; p < NP; p++) begin : g_pin
		logic [`PFS_FLD_SEL_W-1:0] code;
		logic code_ok;
		logic is_ref_pin;

		assign code = cfg_reg[p].function_select;
		// code zero and unassigned codes both float the pad  see R01 see R21
		assign code_ok = (code != `PFS_CODE_HIZ) && VALID[p][code];
		assign is_ref_pin = (p == PIN_J6) || (p == PIN_J7);

		always_comb begin
			cfg_next[p] = cfg_reg[p];
			if (reg_wr_in && addr8 == OFFS[p]) begin
				cfg_next[p] = pfs_pkg::pfs_cfg_t'(reg_wdata_in & WMASK[p]); // see R01
			end
			// in legacy mode J6/J7 analog bit only steers the reference  see R06 see R07
			ana_next[p] = cfg_reg[p].analog_function_select && !(legacy_mode_reg && is_ref_pin); // see R04
			dig_block[p] = ana_next[p]; // see R22
			// analog use also takes the pad away from the digital driver
			pad_out_next[p] = 1'b0;
			pad_oe_next[p] = 1'b0;
			rx_next[p] = '0;
			if (code_ok && !dig_block[p]) begin
				pad_out_next[p] = periph_drive_in[p].data[code];
				pad_oe_next[p] = periph_drive_in[p].oe[code];
				rx_next[p][code] = pad_sync_reg[p]; // see R22
			end
			irq_active[p] = cfg_reg[p].interrupt_input_select && IRQ_MAP[p][3]
				&& !dig_block[p] && pad_sync_reg[p]; // see R02 see R20
		end

		// routing follows the control word from the cycle after it is written  see R22
		always_ff @(posedge core_clk_in) begin
			if (!resetn_in) begin
				cfg_reg[p] <= pfs_pkg::pfs_cfg_t'(`PFS_RST_CFG);
				pad_out[p] <= 1'b0;
				pad_oe_out[p] <= 1'b0;
				periph_rx_out[p] <= '0;
				analog_connect_out[p] <= 1'b0;
			end else begin
				cfg_reg[p] <= cfg_next[p];
				pad_out[p] <= pad_out_next[p];
				pad_oe_out[p] <= pad_oe_next[p];
				periph_rx_out[p] <= rx_next[p];
				analog_connect_out[p] <= ana_next[p];
			end
		end
	end

	// several pins may share one line; the line shows their OR
	always_comb begin
		irq_next = '0;
		for (int p = 0; p < NP; p++) begin
			if (irq_active[p]) begin
				irq_next[IRQ_MAP[p][2:0]] = 1'b1; // see R03
			end
		end
	end

	// reads: unmapped offsets and unimplemented bits return zero
	always_comb begin
		rdata_next = '0;
		if (reg_rd_in) begin
			for (int p = 0; p < NP; p++) begin
				if (addr8 == OFFS[p]) begin
					rdata_next = cfg_reg[p] & WMASK[p];
				end
			end
			if (addr8 == `PFS_OFF_MODE) begin
				rdata_next[`PFS_FLD_LEGACY_BIT] = legacy_mode_reg;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= '0;
			external_interrupt_line_out <= '0;
			converter_channel_out <= '0;
			comparator_connect_out <= '0;
			converter_high_reference_out <= 1'b0;
			converter_low_reference_out <= 1'b0;
		end else begin
			reg_rdata_out <= rdata_next;
			external_interrupt_line_out <= irq_next;
			for (int i = 0; i < 6; i++) begin
				converter_channel_out[i] <= cfg_reg[PIN_E0 + i].analog_function_select; // see R05
			end
			comparator_connect_out <= {cfg_reg[PIN_E4].analog_function_select,
				cfg_reg[PIN_E2].analog_function_select,
				cfg_reg[PIN_E1].analog_function_select}; // see R05
			// 1: dedicated reference pin, 0: analog supply / ground  see R04 see R06 see R07
			converter_high_reference_out <= cfg_reg[PIN_J6].analog_function_select;
			converter_low_reference_out <= cfg_reg[PIN_J7].analog_function_select;
		end
	end

endmodule : pfs_pin_mux

// ==== inc/pfs_map.svh ====
/*
 * Register map of the pin function select multiplexer: offsets, field
 * positions, reset values. Assumes a byte-wide register port indexed by word.
 */
`ifndef PFS_MAP_SVH
`define PFS_MAP_SVH

`define PFS_NUM_PINS 25
`define PFS_NUM_CODES 32
`define PFS_NUM_IRQ 8
`define PFS_DATA_W 8

`define PFS_OFF_PA0 8'h00
`define PFS_OFF_PA1 8'h01
`define PFS_OFF_PA3 8'h02
`define PFS_OFF_PA4 8'h03
`define PFS_OFF_PA6 8'h04
`define PFS_OFF_PB0 8'h05
`define PFS_OFF_PB1 8'h06
`define PFS_OFF_PB3 8'h07
`define PFS_OFF_PB5 8'h08
`define PFS_OFF_PB6 8'h09
`define PFS_OFF_PB7 8'h0a
`define PFS_OFF_PC2 8'h0b
`define PFS_OFF_PC3 8'h0c
`define PFS_OFF_PC4 8'h0d
`define PFS_OFF_PC5 8'h0e
`define PFS_OFF_PC6 8'h0f
`define PFS_OFF_PC7 8'h10
`define PFS_OFF_PE0 8'h11
`define PFS_OFF_PE1 8'h12
`define PFS_OFF_PE2 8'h13
`define PFS_OFF_PE3 8'h14
`define PFS_OFF_PE4 8'h15
`define PFS_OFF_PE5 8'h16
`define PFS_OFF_PJ6 8'h17
`define PFS_OFF_PJ7 8'h18
`define PFS_OFF_MODE 8'h1f

`define PFS_FLD_SEL_LSB 0
`define PFS_FLD_SEL_W 5
`define PFS_FLD_IRQ_BIT 6
`define PFS_FLD_ANA_BIT 7
`define PFS_FLD_LEGACY_BIT 0

`define PFS_RST_CFG 8'h00
`define PFS_RST_MODE 1'b0
`define PFS_CODE_HIZ 5'h00

`endif

// ==== inc/pfs_pkg.sv ====
/*
 * Types of the pin function select multiplexer.
 * Assumes pfs_map.svh is on the include path.
 */
`include "pfs_map.svh"

package pfs_pkg;

	// one pin control word as software sees it
	typedef struct packed {
		logic analog_function_select;
		logic interrupt_input_select;
		logic spare;
		logic [`PFS_FLD_SEL_W-1:0] function_select;
	} pfs_cfg_t;

	// what the peripherals offer one pin, one bit per select code
	typedef struct packed {
		logic [`PFS_NUM_CODES-1:0] data;
		logic [`PFS_NUM_CODES-1:0] oe;
	} pfs_drive_t;

endpackage : pfs_pkg

// ==== tb/pfs_periph_model.sv ====
/* peripheral side of the pin mux: offers one data pattern and a drive
   request on every select code of every pin; the bench steers the pattern */
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_periph_model (
	input wire logic [31:0] pat_in,
	output pfs_pkg::pfs_drive_t drive_out [`PFS_NUM_PINS]
);
	// every peripheral asks to drive, so only the mux can keep a pin floating
	always_comb begin
		for (int i = 0; i < `PFS_NUM_PINS; i++) begin
			drive_out[i].data = pat_in;
			drive_out[i].oe = 32'hffffffff;
		end
	end
endmodule : pfs_periph_model

// ==== tb/pfs_pin_mux_sva.sv ====
/* port assertions of the pin mux; bound to pfs_pin_mux below.
   assumes the pin order and field layout of pfs_map.svh */
`timescale 1ns/1ps
`include "pfs_map.svh"
module pfs_pin_mux_sva #(
	parameter int ADDR_W = 8
) (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [`PFS_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic [`PFS_DATA_W-1:0] reg_rdata_out,
	input wire logic [`PFS_NUM_PINS-1:0] pad_in,
	input wire logic [`PFS_NUM_PINS-1:0] pad_oe_out,
	input wire logic [`PFS_NUM_IRQ-1:0] external_interrupt_line_out,
	input wire logic [`PFS_NUM_PINS-1:0] analog_connect_out,
	input wire logic [5:0] converter_channel_out,
	input wire logic [2:0] comparator_connect_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_reset_floats: assert property (disable iff (1'b0) !resetn_in |=> pad_oe_out == '0 && reg_rdata_out == '0)
		else $error("outputs not cleared by reset");
	a_code_floats: assert property (reg_wr_in && reg_addr_in == 0 && reg_wdata_in[4:0] inside {5'h00, 5'h02}
		|=> ##1 !pad_oe_out[0]) else $error("pin driven with empty code");
	a_unused_lines: assert property (external_interrupt_line_out[3:0] == 4'h0)
		else $error("interrupt line without source");
	a_line6_src: assert property (external_interrupt_line_out[6] |-> $past(pad_in[2], 3))
		else $error("line 6 not from its pin");
	a_line7_src: assert property (external_interrupt_line_out[7] |-> $past(pad_in[19], 3))
		else $error("line 7 not from its pin");
	a_channel_map: assert property (converter_channel_out == analog_connect_out[22:17])
		else $error("converter channel mismatch");
	a_comparator_map: assert property (comparator_connect_out ==
		{analog_connect_out[21], analog_connect_out[19], analog_connect_out[18]}) else $error("comparator mismatch");
	a_analog_no_drive: assert property ((pad_oe_out & analog_connect_out) == '0)
		else $error("analog pin driven");
endmodule : pfs_pin_mux_sva
bind pfs_pin_mux pfs_pin_mux_sva #(.ADDR_W(ADDR_W)) i_sva (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
	.pad_in(pad_in), .pad_oe_out(pad_oe_out), .external_interrupt_line_out(external_interrupt_line_out),
	.analog_connect_out(analog_connect_out), .converter_channel_out(converter_channel_out),
	.comparator_connect_out(comparator_connect_out));

// ==== tb/pfs_pin_mux_test.sv ====
/* register-call tests of the pin mux against the peripheral model.
   assumes registers in pin order and a two-stage pad synchroniser */
`timescale 1ns/1ps
`include "pfs_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module pfs_pin_mux_test;
	logic core_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [24:0] pad_in = '0;
	logic [31:0] pat = 32'h5a5ac3c3;
	logic [7:0] rdata;
	logic [7:0] irq;
	logic [24:0] pad_out;
	logic [24:0] pad_oe;
	logic [24:0] ana;
	logic [5:0] chan;
	logic [2:0] cmp;
	logic href;
	logic lref;
	logic [31:0] rx [`PFS_NUM_PINS];
	pfs_pkg::pfs_drive_t drive [`PFS_NUM_PINS];
	int fails = 0;
	int checks_done = 0;
	logic [7:0] mask [25] = '{8'h9f, 8'h9f, 8'hdf, 8'hdf, 8'h9f, 8'h1f, 8'h5f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h1f,
		8'h1f, 8'h1f, 8'h1f, 8'h1f, 8'h9f, 8'h9f, 8'hdf, 8'h9f, 8'h9f, 8'hdf, 8'h80, 8'h80};
	// {assigned, pin, code}
	logic [10:0] route [17] = '{11'h401, 11'h407, 11'h40d, 11'h419, 11'h002, 11'h42a, 11'h444, 11'h465, 11'h487,
		11'h4d0, 11'h4fb, 11'h5b9, 11'h5ea, 11'h61b, 11'h689, 11'h6d0, 11'h2c3};
	logic [7:0] irq_pin [5] = '{8'h02, 8'h03, 8'h06, 8'h13, 8'h16};
	int irq_num [5] = '{6, 5, 4, 7, 5};
	pfs_periph_model i_model (.pat_in(pat), .drive_out(drive));
	pfs_pin_mux i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe),
		.periph_drive_in(drive), .periph_rx_out(rx), .external_interrupt_line_out(irq), .analog_connect_out(ana),
		.converter_channel_out(chan), .comparator_connect_out(cmp), .converter_high_reference_out(href),
		.converter_low_reference_out(lref));
	initial begin
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : tick
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge core_clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge core_clk_in);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd_reg
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : complete_run
	initial begin
		tick(20);
		@(posedge core_clk_in);
		resetn_in <= 1'b1;
		for (int i = 0; i < 25; i++) rd_reg(8'(i), 8'h00);
		for (int i = 0; i < 26; i++) begin
			wr_reg(8'(i), 8'hff);
			rd_reg(8'(i), i < 25 ? mask[i] : 8'h00);
			wr_reg(8'(i), 8'h00);
		end
		rd_reg(8'h1f, 8'h00);
		$display("test registers done");
		@(posedge core_clk_in);
		pad_in <= '1;
		foreach (route[k]) begin
			wr_reg({3'h0, route[k][9:5]}, {3'h0, route[k][4:0]});
			tick(4);
			`CHK("oe", route[k][10], pad_oe[route[k][9:5]])
			`CHK("out", pat[route[k][4:0]] & route[k][10], pad_out[route[k][9:5]] & route[k][10])
			`CHK("rx", route[k][10], rx[route[k][9:5]][route[k][4:0]])
			@(posedge core_clk_in);
			pat <= ~pat;
			tick(2);
			`CHK("out", pat[route[k][4:0]] & route[k][10], pad_out[route[k][9:5]] & route[k][10])
			wr_reg({3'h0, route[k][9:5]}, 8'h00);
		end
		$display("test routing done");
		wr_reg(8'h12, 8'h81);
		wr_reg(8'h13, 8'h80);
		wr_reg(8'h15, 8'h80);
		wr_reg(8'h17, 8'h80);
		tick(4);
		`CHK("chan", 6'h16, chan)
		`CHK("cmp", 3'h7, cmp)
		`CHK("ana", 25'h0ac0000, ana)
		`CHK("oe e1", 1'b0, pad_oe[18])
		`CHK("rx e1", 1'b0, rx[18][1])
		`CHK("href", 1'b1, href)
		wr_reg(8'h1f, 8'h01);
		rd_reg(8'h1f, 8'h01);
		wr_reg(8'h18, 8'h80);
		wr_reg(8'h17, 8'h00);
		tick(4);
		`CHK("lref", 1'b1, lref)
		`CHK("href", 1'b0, href)
		`CHK("ana j", 2'b00, ana[24:23])
		wr_reg(8'h18, 8'h00);
		wr_reg(8'h17, 8'h80);
		tick(4);
		`CHK("lref", 1'b0, lref)
		`CHK("href", 1'b1, href)
		wr_reg(8'h1f, 8'h00);
		$display("test analog done");
		foreach (irq_pin[k]) begin
			wr_reg(irq_pin[k], 8'h40);
			tick(4);
			`CHK("irq", 8'h01 << irq_num[k], irq)
			// the line must follow the pad level, not just the select bit
			@(posedge core_clk_in);
			pad_in <= '0;
			tick(4);
			`CHK("irq low", 8'h00, irq)
			@(posedge core_clk_in);
			pad_in <= '1;
			wr_reg(irq_pin[k], 8'h00);
			tick(4);
			`CHK("irq off", 8'h00, irq)
		end
		wr_reg(8'h0d, 8'h40);
		wr_reg(8'h04, 8'h40);
		tick(4);
		`CHK("irq c4 a6", 8'h00, irq)
		$display("test interrupts done");
		// mid-run reset must drop the analog setup left on E1 and E4
		@(posedge core_clk_in);
		resetn_in <= 1'b0;
		tick(2);
		@(posedge core_clk_in);
		resetn_in <= 1'b1;
		rd_reg(8'h12, 8'h00);
		`CHK("chan rst", 6'h00, chan)
		$display("test reset done");
		complete_run();
	end
endmodule : pfs_pin_mux_test
